// >>> rtl/dpc_consts.svh
// Register offsets, field positions, reset values and timing figures of the oscillator period control.
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH
`define DPC_CLK_HZ 20000000
`define DPC_CLK_MHZ 20
`define DPC_BASE_HZ 307200
`define DPC_MON_TIMEOUT_NS 100000
`define DPC_A_CTRL 8'h00
`define DPC_A_STATUS 8'h04
`define DPC_A_REF 8'h08
`define DPC_A_IST 8'h0C
`define DPC_A_IMASK 8'h10
`define DPC_CTRL_OSC 16
`define DPC_CTRL_MON 17
`define DPC_ST_STABLE 16
`define DPC_ST_MONF 17
`define DPC_EV_STABLE 0
`define DPC_EV_MONF 1
`define DPC_EV_SAT 2
`define DPC_N_RST 8'h01
`define DPC_TRIM_RST 8'h80
`define DPC_STG_RST 8'h80
`define DPC_DIV_RST 4'h1
`define DPC_DIV_MAX 4'h9
`define DPC_LEN_MIN 6'h11
`define DPC_LEN_TOP 6'h22
`define DPC_STEP_COARSE 8'h20
`define DPC_STEP_MID 8'h08
`define DPC_STEP_FINE 8'h01
`define DPC_ERR_DEN 30'h00000014
`define DPC_ERR_COARSE 30'h00000003
`define DPC_ERR_STABLE 30'h00000001
`define DPC_CORR_LAST 2'h3
`define DPC_RESP_OK 2'h0
`define DPC_RESP_ERR 2'h2
`endif

// >>> rtl/dpc_pkg.sv
// Types and shared helpers of the oscillator period control.
`default_nettype none
package dpc_pkg;
  // Loop filter settling regions.
  typedef enum logic [1:0] {
    DPC_OFF = 2'b00,
    DPC_COARSE = 2'b01,
    DPC_MID = 2'b10,
    DPC_FINE = 2'b11
  } dpc_mode_t;

  // Ring emulator state.
  typedef struct packed {
    logic [5:0] stage_cnt;
    logic [9:0] ring_div;
    logic [4:0] phase;
    logic long_cyc;
    logic tick;
  } dpc_osc_state_t;

  // Controller state.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [7:0] mult;
    logic [7:0] trim;
    logic osc_on;
    logic mon_on;
    logic [23:0] refc;
    logic [2:0] imask;
    logic [2:0] ist;
    logic irq;
    logic [7:0] stg;
    logic [3:0] div;
    logic stable;
    logic mon_flag;
    dpc_mode_t mode;
    logic [7:0] n_cnt;
    logic [1:0] corr_cnt;
    logic [23:0] meas;
    logic [11:0] mon_cnt;
  } dpc_state_t;

  // Divider codes above the top code act as the top code.
  function automatic logic [3:0] dpc_clamp_div(input logic [3:0] d);
    dpc_clamp_div = (d > 4'h9) ? 4'h9 : d;
  endfunction
endpackage
`default_nettype wire

// >>> rtl/dpc_osc_if.sv
// Carrier between the loop filter and the ring emulator.
`timescale 1ns/1ps
`default_nettype none
interface dpc_osc_if;
  logic [7:0] stage_control;
  logic [3:0] divider_select;
  logic run;
  logic tick;
  modport ctrl (output stage_control, output divider_select, output run, input tick);
  modport osc (input stage_control, input divider_select, input run, output tick);
endinterface
`default_nettype wire

// >>> rtl/dpc_digital_osc.sv
// Ring emulator: counts stage delays, dithers the ring length and divides the ring output.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_consts.svh"
module dpc_digital_osc
  import dpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dpc_osc_if.osc osc
);
  dpc_osc_state_t s; // Registered state.
  dpc_osc_state_t next_s; // Next state.
  logic [3:0] div_e; // Clamped divider code.
  logic [5:0] nom_len; // Nominal ring length.
  logic [5:0] cur_len; // Length of the ring cycle now running.
  logic [5:0] acc; // Dither accumulator sum.
  logic ring_end; // Last stage delay of a ring cycle.

  // One stage delay per clock keeps the emulation slow but exact in its ratios.
  always_comb begin
    div_e = dpc_clamp_div(osc.divider_select);
    nom_len = `DPC_LEN_MIN + {2'h0, osc.stage_control[7:5], 1'b0};
    if (!s.long_cyc) begin
      cur_len = nom_len;
    end else if (osc.stage_control[7:5] == 3'h7) begin
      cur_len = `DPC_LEN_TOP;
    end else begin
      cur_len = nom_len + 6'h02;
    end
    ring_end = ({1'b0, s.stage_cnt} + 7'h01) >= {1'b0, cur_len};
    acc = {1'b0, s.phase} + {1'b0, osc.stage_control[4:0]};
    next_s = s;
    next_s.tick = 1'b0;
    if (!osc.run) begin
      next_s = '0;
    end else if (ring_end) begin
      // The accumulator spreads k long cycles evenly over each frame of 32 ring cycles.
      next_s.stage_cnt = 6'h00;
      next_s.phase = acc[4:0];
      next_s.long_cyc = acc[5];
      if ((s.ring_div + 10'h001) >= (10'h001 << div_e)) begin
        next_s.ring_div = 10'h000;
        next_s.tick = 1'b1;
      end else begin
        next_s.ring_div = s.ring_div + 10'h001;
      end
    end else begin
      next_s.stage_cnt = s.stage_cnt + 6'h01;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign osc.tick = s.tick;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  len_range_a: assert property (osc.run |-> (cur_len >= 6'h11 && cur_len <= 6'h22))
    else $error("ring length out of range");
  no_dither_a: assert property ((osc.run && osc.stage_control[4:0] == 5'h00 && ring_end) |=> !s.long_cyc)
    else $error("long cycle without dither code");
  top_long_a: assert property ((osc.run && ring_end && osc.stage_control[7:5] == 3'h7 && s.long_cyc)
                               |-> s.stage_cnt == 6'h21)
    else $error("top code long cycle is not 34 delays");
  undivided_a: assert property ((osc.run && dpc_clamp_div(osc.divider_select) == 4'h0 && ring_end) |=> s.tick)
    else $error("undivided ring cycle gave no tick");
  long_cyc_c: cover property (osc.run && s.long_cyc && ring_end);
endmodule
`default_nettype wire

// >>> rtl/dpc_top.sv
// Oscillator period control: loop filter, monitor, interrupts and AXI4-Lite registers.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_consts.svh"
module dpc_top
  import dpc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic IRQ
);
  // Monitor timeout in clock cycles, derived from the timeout in nanoseconds.
  localparam int MON_CYCLES = `DPC_MON_TIMEOUT_NS * `DPC_CLK_MHZ / 1000;
  // Four nominal base periods in clock cycles sets the default reference window.
  localparam int REF_CYCLES = 4 * `DPC_CLK_HZ / `DPC_BASE_HZ;

  if (MON_CYCLES < 1 || MON_CYCLES > 4095) begin : g_chk
    $error("monitor timeout does not fit its counter");
  end

  logic rst_meta; // First reset flop, read only by the second.
  logic rst_n; // Released reset used by all logic.
  dpc_state_t s; // Registered state.
  dpc_state_t next_s; // Next state.
  dpc_osc_if osc_bus(); // Link to the ring emulator.
  logic wr_fire; // Both halves of a write are held.
  logic rd_fire; // Read address taken.
  logic restart; // Settling must begin again.
  logic apply; // A correction is due now.
  logic base_tick; // One base clock period ended.
  logic [23:0] err; // Magnitude of window error.
  logic [29:0] err_sc; // Error scaled by the denominator.
  logic [29:0] ref_co; // Coarse region threshold.
  logic [29:0] ref_st; // Stable region threshold.
  logic [7:0] step; // Size of this correction.
  logic [11:0] stepped; // Divider and stage after the correction.
  logic sat_hit; // Correction ran into a divider end.
  logic [2:0] ev; // Interrupt events of this cycle.
  logic [31:0] ctrl_new; // Register word after byte strobes.
  logic [7:0] lim; // Multiplier with zero read as one.

  // Returns 1 for a mapped register offset; used by both read and write paths.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `DPC_A_CTRL) || (a == `DPC_A_STATUS) || (a == `DPC_A_REF) ||
             (a == `DPC_A_IST) || (a == `DPC_A_IMASK);
  endfunction

  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // Adds or subtracts a step from the combined output; the divider only follows a carry or borrow.
  function automatic logic [12:0] step_out(input logic [3:0] d, input logic [7:0] g, input logic [7:0] st,
                                           input logic down);
    logic [8:0] sum;
    logic [3:0] de;
    de = dpc_clamp_div(d);
    sum = down ? ({1'b0, g} - {1'b0, st}) : ({1'b0, g} + {1'b0, st});
    if (!sum[8]) begin
      step_out = {1'b0, de, sum[7:0]};
    end else if (!down && de == `DPC_DIV_MAX) begin
      step_out = {1'b1, `DPC_DIV_MAX, 8'hFF};
    end else if (down && de == 4'h0) begin
      step_out = {1'b1, 4'h0, 8'h00};
    end else if (down) begin
      step_out = {1'b0, de - 4'h1, sum[7:0]};
    end else begin
      step_out = {1'b0, de + 4'h1, sum[7:0]};
    end
  endfunction

  // Reset release through two flops; assertion stays asynchronous.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Ring emulator; it sees a new stage or divider as soon as the state register takes it.
  dpc_digital_osc u_osc (
    .clk(CLOCK),
    .rst_n(rst_n),
    .osc(osc_bus.osc)
  );

  assign osc_bus.stage_control = s.stg;
  assign osc_bus.divider_select = s.div;
  assign osc_bus.run = s.osc_on;

  // All next-state logic: bus slave, register writes, loop filter, monitor and interrupts.
  always_comb begin
    next_s = s;
    ev = 3'h0;
    restart = 1'b0;
    ctrl_new = 32'h00000000;
    lim = (s.mult == 8'h00) ? 8'h01 : s.mult;
    // Write address and data are accepted in either order and held until the response.
    if (S_AXI_AWVALID && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.waddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = S_AXI_WDATA;
      next_s.wstrb = S_AXI_WSTRB;
    end
    wr_fire = s.aw_got && s.w_got && !s.bvalid;
    if (s.bvalid && S_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.waddr) ? `DPC_RESP_OK : `DPC_RESP_ERR;
      case (s.waddr)
        `DPC_A_CTRL: begin
          ctrl_new = merge({14'h0, s.mon_on, s.osc_on, s.trim, s.mult}, s.wdata, s.wstrb);
          next_s.mult = ctrl_new[7:0];
          next_s.trim = ctrl_new[15:8];
          next_s.osc_on = ctrl_new[`DPC_CTRL_OSC];
          // Setting the monitor is refused while the clock is not stable.
          if (!ctrl_new[`DPC_CTRL_MON]) begin
            next_s.mon_on = 1'b0;
          end else if (s.stable) begin
            next_s.mon_on = 1'b1;
          end
          // A changed multiplier, trim or a fresh enable starts settling over.
          restart = (ctrl_new[7:0] != s.mult) || (ctrl_new[15:8] != s.trim) ||
                    (ctrl_new[`DPC_CTRL_OSC] && !s.osc_on);
        end
        `DPC_A_REF: begin
          // Only the low three lanes exist; the top lane is dropped on purpose.
          ctrl_new = merge({8'h00, s.refc}, s.wdata, s.wstrb);
          next_s.refc = ctrl_new[23:0];
        end
        `DPC_A_IMASK: begin
          ctrl_new = merge({29'h0, s.imask}, s.wdata, s.wstrb);
          next_s.imask = ctrl_new[2:0];
        end
        default: begin
        end
      endcase
    end
    // A ready drops while its item is held or a response still waits.
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    // Read path answers one cycle after the address is taken.
    rd_fire = S_AXI_ARVALID && s.arready;
    if (s.rvalid && S_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = mapped(S_AXI_ARADDR) ? `DPC_RESP_OK : `DPC_RESP_ERR;
      case (S_AXI_ARADDR)
        `DPC_A_CTRL: next_s.rdata = {14'h0, s.mon_on, s.osc_on, s.trim, s.mult};
        `DPC_A_STATUS: next_s.rdata = {14'h0, s.mon_flag, s.stable, 4'h0, s.div, s.stg};
        `DPC_A_REF: next_s.rdata = {8'h00, s.refc};
        `DPC_A_IST: next_s.rdata = {29'h0, s.ist};
        `DPC_A_IMASK: next_s.rdata = {29'h0, s.imask};
        default: next_s.rdata = 32'h00000000;
      endcase
    end
    next_s.arready = !next_s.rvalid;
    // Base clock is the internal clock divided by the multiplier.
    base_tick = osc_bus.tick && ({1'b0, s.n_cnt} + 9'h001 >= {1'b0, lim});
    if (osc_bus.tick) begin
      next_s.n_cnt = base_tick ? 8'h00 : s.n_cnt + 8'h01;
    end
    // The window of four base periods is measured in clock cycles against the reference.
    apply = base_tick && s.corr_cnt == `DPC_CORR_LAST;
    next_s.meas = (s.meas == 24'hFFFFFF) ? s.meas : s.meas + 24'h000001;
    if (base_tick) begin
      next_s.corr_cnt = s.corr_cnt + 2'h1;
    end
    // Error and thresholds are scaled up so that no divider is needed.
    err = (s.meas > s.refc) ? s.meas - s.refc : s.refc - s.meas;
    err_sc = {6'h00, err} * `DPC_ERR_DEN;
    ref_co = {6'h00, s.refc} * `DPC_ERR_COARSE;
    ref_st = {6'h00, s.refc} * `DPC_ERR_STABLE;
    // Outside a correction the stage and divider stand still.
    step = 8'h00;
    stepped = {s.div, s.stg};
    sat_hit = 1'b0;
    if (apply) begin
      // The next window already holds the cycle after this edge, so it starts at one.
      next_s.meas = 24'h000001;
      if (err_sc > ref_co) begin
        next_s.mode = DPC_COARSE;
      end else if (err_sc >= ref_st) begin
        next_s.mode = DPC_MID;
      end else begin
        next_s.mode = DPC_FINE;
      end
      // Mid and fine steps are small against their error bands, so those cannot jump over the next band; a coarse step down from a 19-stage ring can.
      case (next_s.mode)
        DPC_COARSE: step = `DPC_STEP_COARSE;
        DPC_MID: step = `DPC_STEP_MID;
        DPC_FINE: step = (err == 24'h000000) ? 8'h00 : `DPC_STEP_FINE;
        default: step = 8'h00;
      endcase
      // A long window means too slow, so the period shrinks.
      {sat_hit, stepped} = step_out(s.div, s.stg, step, s.meas > s.refc);
      next_s.div = stepped[11:8];
      next_s.stg = stepped[7:0];
      if (next_s.mode == DPC_FINE) begin
        next_s.stable = 1'b1;
      end
    end
    // Monitor flags a base clock that has gone quiet too long.
    if (!s.mon_on || base_tick) begin
      next_s.mon_cnt = 12'h000;
    end else if (s.mon_cnt != MON_CYCLES[11:0]) begin
      next_s.mon_cnt = s.mon_cnt + 12'h001;
    end else begin
      next_s.mon_flag = 1'b1;
    end
    if (!next_s.mon_on) begin
      next_s.mon_flag = 1'b0;
    end
    // Settling progress is wiped, but the stage and divider keep their values as a starting point.
    if (restart || !s.osc_on) begin
      next_s.stable = 1'b0;
      next_s.mode = DPC_OFF;
      next_s.corr_cnt = 2'h0;
      next_s.n_cnt = 8'h00;
      next_s.meas = 24'h000000;
    end
    // Events are sticky; a read of the interrupt status clears it but a new event wins.
    ev[`DPC_EV_STABLE] = next_s.stable && !s.stable;
    ev[`DPC_EV_MONF] = next_s.mon_flag && !s.mon_flag;
    ev[`DPC_EV_SAT] = sat_hit;
    if (rd_fire && S_AXI_ARADDR == `DPC_A_IST) begin
      next_s.ist = ev;
    end else begin
      next_s.ist = s.ist | ev;
    end
    // The interrupt is computed from next values so the pin comes straight from a flop.
    next_s.irq = |(next_s.ist & next_s.imask);
  end

  // State register; everything lands in known values at reset.
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.mult <= `DPC_N_RST;
      s.trim <= `DPC_TRIM_RST;
      s.osc_on <= 1'b1;
      s.refc <= REF_CYCLES[23:0];
      s.stg <= `DPC_STG_RST;
      s.div <= `DPC_DIV_RST;
      s.mode <= DPC_OFF;
    end else begin
      s <= next_s;
    end
  end

  // Every output is a field of the state register.
  assign S_AXI_AWREADY = s.awready;
  assign S_AXI_WREADY = s.wready;
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_ARREADY = s.arready;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RDATA = s.rdata;
  assign S_AXI_RRESP = s.rresp;
  assign IRQ = s.irq;

  // Checks on the loop filter, the monitor and the interrupt logic.
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  div_sat_a: assert property (s.div <= 4'h9)
    else $error("divider code above nine");
  div_carry_a: assert property ((s.div != $past(s.div)) |-> $past(apply && step != 8'h00))
    else $error("divider moved without a correction");
  coarse_step_a: assert property ((apply && step == 8'h20 && !sat_hit) |=> s.stg[4:0] == $past(s.stg[4:0]))
    else $error("coarse correction touched fine bits");
  fine_step_a: assert property ((apply && step == 8'h01 && !sat_hit && s.meas < s.refc)
                                |=> {s.div, s.stg} == $past({s.div, s.stg}) + 12'h001)
    else $error("fine correction was not one step");
  mon_refuse_a: assert property ($rose(s.mon_on) |-> $past(s.stable))
    else $error("monitor enabled while unstable");
  restart_a: assert property (restart |=> !s.stable ##1 s.corr_cnt <= 2'h1)
    else $error("settling did not restart");
  window_a: assert property ((base_tick && s.osc_on && !restart)
                             |=> s.corr_cnt == $past(s.corr_cnt) + 2'h1)
    else $error("correction outside a four period window");
  stable_set_a: assert property ((apply && err_sc < ref_st && !restart && s.osc_on) |=> s.stable)
    else $error("stable flag missed below five percent");
  irq_a: assert property (s.irq == |(s.ist & s.imask))
    else $error("interrupt output disagrees with status and mask");
  // Cover points for the main scenarios.
  stable_c: cover property ($rose(s.stable));
  div_step_c: cover property (s.div != $past(s.div));
  mon_on_c: cover property ($rose(s.mon_on));
  sat_c: cover property (sat_hit);
endmodule
`default_nettype wire

// >>> verif/dco_period_control_bench.sv
// Self-checking bench for the oscillator period control block.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_consts.svh"
module dco_period_control_bench;
  // Bench side of every top-level port.
  logic clock, rst_n, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int err_count = 0;
  int total_checks = 0;
  int seed = 46319;
  int cur_n = 1;
  // Reset image of the register map, status first so the loop has not moved yet.
  localparam logic [7:0] RA [5] = '{`DPC_A_STATUS, `DPC_A_CTRL, `DPC_A_REF, `DPC_A_IST, `DPC_A_IMASK};
  localparam logic [31:0] RV [5] = '{32'h180, 32'h18001, 32'h104, 32'h0, 32'h0};

  dpc_top uut (.CLOCK(clock), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IRQ(irq));

  // Free-running 20 MHz clock.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One comparison; case inequality so an unknown never matches.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  // A bounded wait ran out, so the run stops here.
  task automatic hang(input string what);
    $display("FAIL %s expected handshake seen timeout", what);
    err_count++;
    finish_test();
  endtask

  // Write: address and data offered together, each dropped once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    if (n >= 200) hang("write response");
    r = bresp;
    bready <= 1'b0;
    // One spare edge keeps the next request out of this time step.
    @(posedge clock);
  endtask

  // Read: address held until taken, data captured with the response.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    if (n >= 200) hang("read data");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask

  // Whole-word write whose response is not of interest.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'hF, r);
  endtask

  // Read whose response is not of interest.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd(a, d, r);
  endtask

  // Polls status until the masked bits match; the loop needs many corrections to get there.
  task automatic wait_status(input logic [31:0] mask, input logic [31:0] want, output logic [31:0] st);
    int n;
    n = 0;
    do begin
      repeat (100) @(posedge clock);
      rd(`DPC_A_STATUS, st);
      n++;
    end while ((st & mask) !== want && n < 300);
    if (n >= 300) hang("status wait");
  endtask

  // Clock cycles in four base periods for a given stage and divider setting.
  function automatic int model_cycles(input int n, input logic [11:0] st);
    int len;
    int ext;
    int d;
    len = 17 + 2 * int'(st[7:5]);
    ext = (st[7:5] == 3'h7) ? 3 : 2;
    d = (st[11:8] > 4'h9) ? 9 : int'(st[11:8]);
    return ((4 * (n == 0 ? 1 : n) * (32 * len + ext * int'(st[4:0]))) << d) / 32;
  endfunction

  // Main sequence.
  initial begin
    logic [31:0] d, m;
    logic [1:0] r;
    logic [3:0] s;
    int n, refv, e;
    rst_n = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 5; i++) begin
      rd(RA[i], d);
      chk("reset value", RV[i], d);
    end
    // Unmapped place: refused with an error and no data.
    axi_wr(8'h20, 32'hFFFFFFFF, 4'hF, r);
    chk("unmapped write resp", 32'(`DPC_RESP_ERR), 32'(r));
    axi_rd(8'h20, d, r);
    chk("unmapped read resp", 32'(`DPC_RESP_ERR), 32'(r));
    chk("unmapped read data", 32'h0, d);
    // Random byte lanes into the reference register merge with the old value.
    m = 32'h104;
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      s = 4'($random(seed));
      axi_wr(`DPC_A_REF, d, s, r);
      for (int b = 0; b < 3; b++) if (s[b]) m[8*b +: 8] = d[8*b +: 8];
      rd(`DPC_A_REF, d);
      chk("ref merge", m, d);
    end
    d = $random(seed);
    wr(`DPC_A_IMASK, d);
    m = {29'h0, d[2:0]};
    rd(`DPC_A_IMASK, d);
    chk("mask readback", m, d);
    wr(`DPC_A_IMASK, 32'h1);
    // Two frequency changes, the second with a zero multiplier that acts as one.
    for (int t = 0; t < 2; t++) begin
      n = (t == 0) ? 2 : 0;
      refv = 300 + ($random(seed) & 32'hFF) * 2;
      rd(`DPC_A_STATUS, d);
      chk("monitor flag clear", 32'h0, d & 32'h20000);
      wr(`DPC_A_CTRL, {14'h0, 2'b01, 8'h80, 8'(cur_n)});
      wr(`DPC_A_REF, refv);
      wr(`DPC_A_CTRL, {14'h0, 2'b01, 8'h80, 8'(n)});
      cur_n = n;
      rd(`DPC_A_STATUS, d);
      chk("stable after restart", 32'h0, d & 32'h10000);
      rd(`DPC_A_IST, d);
      wr(`DPC_A_CTRL, {14'h0, 2'b11, 8'h80, 8'(n)});
      rd(`DPC_A_CTRL, d);
      chk("monitor refused", 32'h0, d & 32'h20000);
      wait_status(32'h10000, 32'h10000, d);
      e = model_cycles(n, d[11:0]) - refv;
      if (e < 0) e = -e;
      chk("settled period", 32'h1, 32'(e * 100 <= refv * 7));
      chk("divider range", 32'h1, 32'(d[11:8] <= 4'h9));
      chk("irq on stable", 32'h1, 32'(irq));
      rd(`DPC_A_IST, d);
      chk("stable event", 32'h1, d & 32'h1);
      repeat (2) @(posedge clock);
      chk("irq cleared", 32'h0, 32'(irq));
      wr(`DPC_A_CTRL, {14'h0, 2'b11, 8'h80, 8'(n)});
      rd(`DPC_A_CTRL, d);
      chk("monitor accepted", 32'h20000, d & 32'h20000);
    end
    // Oscillator off with the monitor left on: base ticks stop, the flag rises and stable drops.
    wr(`DPC_A_CTRL, {14'h0, 2'b10, 8'h80, 8'(cur_n)});
    repeat (2100) @(posedge clock);
    rd(`DPC_A_STATUS, d);
    chk("stable when off", 32'h0, d & 32'h10000);
    chk("monitor flag on dead clock", 32'h20000, d & 32'h20000);
    wr(`DPC_A_CTRL, {14'h0, 2'b00, 8'h80, 8'(cur_n)});
    rd(`DPC_A_STATUS, d);
    chk("monitor flag cleared", 32'h0, d & 32'h20000);
    // A tiny reference drives the loop to the fast end, where it must stop.
    wr(`DPC_A_REF, 32'h1);
    wr(`DPC_A_CTRL, {14'h0, 2'b01, 8'h80, 8'(cur_n)});
    rd(`DPC_A_IST, d);
    wait_status(32'hFFF, 32'h0, d);
    repeat (2) @(posedge clock);
    chk("masked irq", 32'h0, 32'(irq));
    rd(`DPC_A_IST, d);
    chk("saturation event", 32'h4, d & 32'h4);
    finish_test();
  end
endmodule
`default_nettype wire
